// ### core/bec_consts.vh
// Constants for the bridge error and lock control block.
// Assumes inclusion by bec_top only; definitions only.
`ifndef BEC_CONSTS_VH
`define BEC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BEC_OFF_CTRL 8'h00
`define BEC_OFF_STAT 8'h04
`define BEC_OFF_CAUSE 8'h08
`define BEC_OFF_DIS 8'h0C
`define BEC_OFF_LOCK 8'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define BEC_CTL_PRI_PRESP 0
`define BEC_CTL_SEC_PRESP 1
`define BEC_CTL_SERR_EN 2
`define BEC_CTL_SERR_FWD 3
`define BEC_CTL_MTO_SERR 4
`define BEC_CTRL_RST 8'h00

// ----------------------------------------
// Status fields
// ----------------------------------------
`define BEC_ST_PRI_PERR_DET 0
`define BEC_ST_PRI_DPAR_DET 1
`define BEC_ST_SIG_SERR 2
`define BEC_ST_SEC_PERR_DET 3
`define BEC_ST_SEC_DPAR_DET 4
`define BEC_ST_RCV_SERR 5

// ----------------------------------------
// Cause and disable fields
// ----------------------------------------
`define BEC_CS_PW_PAR 0
`define BEC_CS_PW_TABT 1
`define BEC_CS_PW_MABT 2
`define BEC_CS_PW_RETRY 3
`define BEC_CS_DW_RETRY 4
`define BEC_CS_DR_RETRY 5
`define BEC_CS_MTO 6
`define BEC_CS_SEC_SERR 7
`define BEC_DIS_RST 8'h00

// ----------------------------------------
// Forwarded transaction kinds
// ----------------------------------------
`define BEC_KIND_PW 2'h0
`define BEC_KIND_DW 2'h1
`define BEC_KIND_DR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define BEC_PERR_DELAY_CYC 2
`define BEC_RETRY_LIMIT 25'h1000000

`endif

// ### core/bec_top.v
// Error signalling and exclusive access control of a two-bus bridge.
// Assumes bridge datapath strobes on clock_i; bus pins arrive unsynchronised.
`timescale 1ns/10ps
`include "bec_consts.vh"

module bec_top #(
   parameter RETRY_LIMIT = `BEC_RETRY_LIMIT,
   parameter AW = 32
)(
   input wire clock_i,
   input wire rst_b_i,
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   input wire dn_pw_perr_i,
   input wire up_pw_perr_i,
   input wire dn_wr_master_i,
   input wire dn_wr_fwd_bad_i,
   input wire up_wr_master_i,
   input wire up_wr_fwd_bad_i,
   input wire primary_parity_error_line_b_i,
   input wire secondary_parity_error_line_b_i,
   input wire secondary_system_error_input_b_i,
   input wire pw_target_abort_i,
   input wire pw_master_abort_i,
   input wire retry_i,
   input wire txn_done_i,
   input wire [1:0] txn_kind_i,
   input wire master_timeout_i,
   input wire lk_rd_req_i,
   input wire [AW-1:0] lk_addr_i,
   input wire [3:0] lk_cmd_i,
   input wire [3:0] lk_be_i,
   input wire lk_par_i,
   input wire queue_ahead_empty_i,
   input wire s_bus_idle_i,
   input wire s_rd_data_done_i,
   input wire s_rd_abort_i,
   input wire rpt_valid_i,
   input wire [AW-1:0] rpt_addr_i,
   input wire [3:0] rpt_cmd_i,
   input wire [3:0] rpt_be_i,
   input wire rpt_lock_seq_i,
   input wire p_lock_b_i,
   input wire p_frame_b_i,
   input wire s_lock_b_i,
   output reg primary_parity_error_line_b_o,
   output reg primary_parity_error_line_oe_o,
   output reg secondary_parity_error_line_b_o,
   output reg secondary_parity_error_line_oe_o,
   output reg primary_system_error_line_b_o,
   output reg primary_system_error_line_oe_o,
   output reg fwd_bad_par_dn_o,
   output reg fwd_bad_par_up_o,
   output reg discard_o,
   output reg target_retry_o,
   output reg target_abort_o,
   output reg return_data_o,
   output reg block_cross_o,
   output reg no_prefetch_o,
   output reg fwd_locked_o,
   output reg issue_lock_rd_o,
   output reg s_lock_b_o,
   output reg s_lock_oe_o,
   output reg [AW-1:0] lk_addr_o,
   output reg [3:0] lk_cmd_o,
   output reg [3:0] lk_be_o,
   output reg lk_par_o
);

   localparam ST_IDLE = 3'h0;
   localparam ST_QUEUED = 3'h1;
   localparam ST_WAIT = 3'h2;
   localparam ST_ADDR = 3'h3;
   localparam ST_DATA = 3'h4;
   localparam ST_HELD = 3'h5;
   localparam ST_ABORT = 3'h6;
   localparam ST_LOCKED = 3'h7;
   // Retry limit cut to the counter's width
   localparam [24:0] RLIM = RETRY_LIMIT[24:0];

   function [7:0] w1c;
      input [7:0] cur;
      input [7:0] clr;
      input [7:0] set;
      begin
         w1c = (cur & ~clr) | set;
      end
   endfunction

   // Secondary lock pulled low in the data, held and locked states, not in abort
   function lock_low;
      input [2:0] st;
      begin
         lock_low = (st == ST_DATA) || (st == ST_HELD) || (st == ST_LOCKED);
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [5:0] sync1_q;
   reg [5:0] sync2_q;
   always @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         sync1_q <= 6'h3F;
         sync2_q <= 6'h3F;
      end
      else
      begin
         sync1_q <= {s_lock_b_i, p_frame_b_i, p_lock_b_i, secondary_system_error_input_b_i,
                     secondary_parity_error_line_b_i, primary_parity_error_line_b_i};
         sync2_q <= sync1_q;
      end
   end
   wire p_perr_seen = ~sync2_q[0];
   wire s_perr_seen = ~sync2_q[1];
   wire s_serr_seen = ~sync2_q[2];
   wire p_lock_rel = sync2_q[3];
   wire p_frame_rel = sync2_q[4];
   wire s_lock_rel = sync2_q[5];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] ctrl_q;
   reg [7:0] stat_q;
   reg [7:0] cause_q;
   reg [7:0] dis_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   wire wr_ctrl = reg_wr_i && (reg_addr_i == `BEC_OFF_CTRL);
   wire wr_stat = reg_wr_i && (reg_addr_i == `BEC_OFF_STAT);
   wire wr_cause = reg_wr_i && (reg_addr_i == `BEC_OFF_CAUSE);
   wire wr_dis = reg_wr_i && (reg_addr_i == `BEC_OFF_DIS);
   wire pri_resp = ctrl_q[`BEC_CTL_PRI_PRESP];
   wire sec_resp = ctrl_q[`BEC_CTL_SEC_PRESP];
   wire serr_en = ctrl_q[`BEC_CTL_SERR_EN];

   // ----------------------------------------
   // Retry counting
   // ----------------------------------------
   reg [24:0] retry_cnt_q;
   wire retry_hit = retry_i && (retry_cnt_q + 25'h1 >= RLIM);
   always @(posedge clock_i)
   begin
      if (!rst_b_i)
         retry_cnt_q <= 25'h0;
      else if (txn_done_i || retry_hit)
         retry_cnt_q <= 25'h0;
      else if (retry_i)
         retry_cnt_q <= retry_cnt_q + 25'h1;
   end

   // ----------------------------------------
   // Target-reported parity errors
   // ----------------------------------------
   wire dn_tgt_perr = dn_wr_master_i && s_perr_seen;
   wire up_tgt_perr = up_wr_master_i && p_perr_seen;

   // ----------------------------------------
   // System error causes
   // ----------------------------------------
   reg [7:0] ev;
   reg [7:0] qual;
   reg [7:0] st_set;
   wire lk_mto = master_timeout_i && (state_q == ST_HELD);
   always @*
   begin
      ev = 8'h00;
      ev[`BEC_CS_PW_PAR] = (dn_tgt_perr && !dn_wr_fwd_bad_i)
                         || (up_tgt_perr && !up_wr_fwd_bad_i);
      ev[`BEC_CS_PW_TABT] = pw_target_abort_i;
      ev[`BEC_CS_PW_MABT] = pw_master_abort_i;
      ev[`BEC_CS_PW_RETRY] = retry_hit && (txn_kind_i == `BEC_KIND_PW);
      ev[`BEC_CS_DW_RETRY] = retry_hit && (txn_kind_i == `BEC_KIND_DW);
      ev[`BEC_CS_DR_RETRY] = retry_hit && (txn_kind_i == `BEC_KIND_DR);
      ev[`BEC_CS_MTO] = master_timeout_i || lk_mto;
      ev[`BEC_CS_SEC_SERR] = s_serr_seen;
      // Disable bits cover the first six; two causes have their own enables
      qual = ev & ~{2'b00, dis_q[5:0]};
      // Parity cause needs both response bits whichever way the write went
      qual[`BEC_CS_PW_PAR] = ev[`BEC_CS_PW_PAR] && pri_resp && sec_resp
                           && !dis_q[`BEC_CS_PW_PAR];
      qual[`BEC_CS_MTO] = ev[`BEC_CS_MTO] && ctrl_q[`BEC_CTL_MTO_SERR];
      qual[`BEC_CS_SEC_SERR] = s_serr_seen && ctrl_q[`BEC_CTL_SERR_FWD];
      if (!serr_en)
         qual = 8'h00;
      st_set = 8'h00;
      st_set[`BEC_ST_PRI_PERR_DET] = dn_pw_perr_i;
      st_set[`BEC_ST_SEC_PERR_DET] = up_pw_perr_i;
      st_set[`BEC_ST_SEC_DPAR_DET] = dn_tgt_perr && sec_resp;
      st_set[`BEC_ST_PRI_DPAR_DET] = up_tgt_perr && pri_resp;
      st_set[`BEC_ST_SIG_SERR] = |qual;
      st_set[`BEC_ST_RCV_SERR] = qual[`BEC_CS_SEC_SERR];
   end

   // ----------------------------------------
   // Register file and error outputs
   // ----------------------------------------
   reg [`BEC_PERR_DELAY_CYC-2:0] dn_perr_pipe_q;
   reg [`BEC_PERR_DELAY_CYC-2:0] up_perr_pipe_q;
   always @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         ctrl_q <= `BEC_CTRL_RST;
         dis_q <= `BEC_DIS_RST;
         stat_q <= 8'h00;
         cause_q <= 8'h00;
         reg_rdata_o <= 32'h0;
         dn_perr_pipe_q <= 1'b0;
         up_perr_pipe_q <= 1'b0;
         primary_parity_error_line_b_o <= 1'b1;
         primary_parity_error_line_oe_o <= 1'b0;
         secondary_parity_error_line_b_o <= 1'b1;
         secondary_parity_error_line_oe_o <= 1'b0;
         primary_system_error_line_b_o <= 1'b1;
         primary_system_error_line_oe_o <= 1'b0;
         fwd_bad_par_dn_o <= 1'b0;
         fwd_bad_par_up_o <= 1'b0;
         discard_o <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= reg_wdata_i[7:0];
         if (wr_dis)
            dis_q <= reg_wdata_i[7:0];
         // Set beats a simultaneous clear
         stat_q <= w1c(stat_q, wr_stat ? reg_wdata_i[7:0] : 8'h00, st_set);
         cause_q <= w1c(cause_q, wr_cause ? reg_wdata_i[7:0] : 8'h00, qual);
         reg_rdata_o <= 32'h0;
         if (reg_rd_i)
         begin
            if (reg_addr_i == `BEC_OFF_CTRL)
               reg_rdata_o <= {24'h0, ctrl_q};
            else if (reg_addr_i == `BEC_OFF_STAT)
               reg_rdata_o <= {24'h0, stat_q};
            else if (reg_addr_i == `BEC_OFF_CAUSE)
               reg_rdata_o <= {24'h0, cause_q};
            else if (reg_addr_i == `BEC_OFF_DIS)
               reg_rdata_o <= {24'h0, dis_q};
            else if (reg_addr_i == `BEC_OFF_LOCK)
               reg_rdata_o <= {29'h0, state_q};
         end
         // Event on cycle 0, pipe on 1, error line on 2
         dn_perr_pipe_q <= dn_pw_perr_i && pri_resp;
         up_perr_pipe_q <= up_pw_perr_i && sec_resp;
         primary_parity_error_line_b_o <= ~dn_perr_pipe_q;
         primary_parity_error_line_oe_o <= dn_perr_pipe_q;
         secondary_parity_error_line_b_o <= ~up_perr_pipe_q;
         secondary_parity_error_line_oe_o <= up_perr_pipe_q;
         fwd_bad_par_dn_o <= dn_pw_perr_i;
         fwd_bad_par_up_o <= up_pw_perr_i;
         primary_system_error_line_b_o <= ~(|qual);
         primary_system_error_line_oe_o <= |qual;
         discard_o <= retry_hit || lk_mto;
      end
   end

   // ----------------------------------------
   // Locked sequence control
   // ----------------------------------------
   wire rpt_match = rpt_valid_i && rpt_lock_seq_i && (rpt_addr_i == lk_addr_o)
                    && (rpt_cmd_i == lk_cmd_o) && (rpt_be_i == lk_be_o);
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (lk_rd_req_i)
               state_d = ST_QUEUED;
         ST_QUEUED:
            if (queue_ahead_empty_i)
               state_d = ST_WAIT;
         ST_WAIT:
            if (s_bus_idle_i && s_lock_rel)
               state_d = ST_ADDR;
         ST_ADDR:
            state_d = ST_DATA;
         ST_DATA:
            if (s_rd_abort_i)
               state_d = ST_ABORT;
            else if (s_rd_data_done_i)
               state_d = ST_HELD;
         ST_HELD:
            if (master_timeout_i)
               state_d = ST_IDLE;
            else if (rpt_match)
               state_d = ST_LOCKED;
         ST_ABORT:
            if (rpt_match || master_timeout_i)
               state_d = ST_IDLE;
         default:
            if (p_lock_rel && p_frame_rel)
               state_d = ST_IDLE;
      endcase
   end

   always @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         state_q <= ST_IDLE;
         target_retry_o <= 1'b0;
         target_abort_o <= 1'b0;
         return_data_o <= 1'b0;
         block_cross_o <= 1'b0;
         no_prefetch_o <= 1'b0;
         fwd_locked_o <= 1'b0;
         issue_lock_rd_o <= 1'b0;
         s_lock_b_o <= 1'b1;
         s_lock_oe_o <= 1'b0;
         lk_addr_o <= {AW{1'b0}};
         lk_cmd_o <= 4'h0;
         lk_be_o <= 4'h0;
         lk_par_o <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == ST_IDLE && lk_rd_req_i)
         begin
            lk_addr_o <= lk_addr_i;
            lk_cmd_o <= lk_cmd_i;
            lk_be_o <= lk_be_i;
            lk_par_o <= lk_par_i;
         end
         target_retry_o <= (state_q == ST_IDLE) && lk_rd_req_i;
         target_abort_o <= (state_q == ST_ABORT) && rpt_match;
         return_data_o <= (state_q == ST_HELD) && rpt_match && !master_timeout_i;
         // Crossings retried from queueing until the locked state is entered or the sequence returns to idle
         block_cross_o <= (state_d != ST_IDLE) && (state_d != ST_LOCKED);
         no_prefetch_o <= state_d != ST_IDLE;
         fwd_locked_o <= state_d == ST_LOCKED;
         issue_lock_rd_o <= state_d == ST_ADDR;
         // Driven high in address phase, driven low from next cycle while held
         s_lock_oe_o <= (state_d == ST_ADDR) || lock_low(state_d);
         s_lock_b_o <= !lock_low(state_d);
      end
   end

endmodule

// ### dv/bec_top_properties.sv
// Concurrent checks on the ports of the bridge error and lock control.
// Assumes bind onto bec_top; one clock, synchronous active low reset.
`timescale 1ns/10ps
module bec_top_props #(
   parameter RETRY_LIMIT = 8
)(
   input wire clock_i,
   input wire rst_b_i,
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire dn_pw_perr_i,
   input wire up_pw_perr_i,
   input wire retry_i,
   input wire txn_done_i,
   input wire lk_rd_req_i,
   input wire secondary_system_error_input_b_i,
   input wire primary_parity_error_line_b_o,
   input wire primary_parity_error_line_oe_o,
   input wire secondary_parity_error_line_b_o,
   input wire secondary_parity_error_line_oe_o,
   input wire primary_system_error_line_b_o,
   input wire primary_system_error_line_oe_o,
   input wire fwd_bad_par_dn_o,
   input wire discard_o,
   input wire target_retry_o,
   input wire no_prefetch_o,
   input wire issue_lock_rd_o,
   input wire s_lock_b_o,
   input wire s_lock_oe_o
);
   reg [4:0] ctrl_q;
   reg [24:0] rcnt_q;
   // ----
   // Shadow of control and retry count
   // ----
   always @(posedge clock_i)
   begin
      if (!rst_b_i)
         ctrl_q <= 5'h00;
      else if (reg_wr_i && reg_addr_i == 8'h00)
         ctrl_q <= reg_wdata_i[4:0];
   end
   always @(posedge clock_i)
   begin
      if (!rst_b_i || txn_done_i || (retry_i && rcnt_q == RETRY_LIMIT - 1))
         rcnt_q <= 25'h0000000;
      else if (retry_i)
         rcnt_q <= rcnt_q + 25'h0000001;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   // ----
   // Properties
   // ----
   a_pri_perr_delay: assert property (dn_pw_perr_i && ctrl_q[0] |-> ##2
      !primary_parity_error_line_b_o && primary_parity_error_line_oe_o)
      else $error("primary parity line not driven");
   a_pri_perr_cause: assert property (primary_parity_error_line_oe_o |->
      $past(dn_pw_perr_i, 2) && $past(ctrl_q[0], 2))
      else $error("primary parity line without cause");
   a_sec_perr_delay: assert property (up_pw_perr_i && ctrl_q[1] |-> ##2
      !secondary_parity_error_line_b_o && secondary_parity_error_line_oe_o)
      else $error("secondary parity line not driven");
   a_fwd_bad_dn: assert property (dn_pw_perr_i |=> fwd_bad_par_dn_o)
      else $error("bad parity not forwarded");
   a_serr_needs_en: assert property (primary_system_error_line_oe_o |->
      $past(ctrl_q[2]) && !primary_system_error_line_b_o)
      else $error("system error while disabled");
   a_serr_fwd: assert property (!secondary_system_error_input_b_i && ctrl_q[2] &&
      ctrl_q[3] |-> ##[2:4] !primary_system_error_line_b_o)
      else $error("secondary system error not forwarded");
   a_retry_limit: assert property (retry_i && rcnt_q == RETRY_LIMIT - 1 |=> discard_o)
      else $error("no discard at retry limit");
   a_lock_retry: assert property (lk_rd_req_i |=> target_retry_o && no_prefetch_o)
      else $error("locked read not retried");
   a_lock_issue: assert property (issue_lock_rd_o |-> s_lock_oe_o && s_lock_b_o ##1
      s_lock_oe_o && !s_lock_b_o)
      else $error("lock not asserted after address phase");
   c_pri_perr: cover property (dn_pw_perr_i && ctrl_q[0]);
   c_lock_issue: cover property (issue_lock_rd_o);
   c_discard: cover property (discard_o);
endmodule

bind bec_top bec_top_props #(.RETRY_LIMIT(RETRY_LIMIT)) u_props (.*);

// ### dv/bec_far_end.sv
// Far side model: bus initiators and targets around the bridge.
// Assumes bench commands on clock_i; released lines float high by pull-up.
`timescale 1ns/10ps
module bec_far_end (
   input wire clock_i,
   input wire [1:0] tgt_perr_i,
   input wire sys_err_i,
   input wire lock_go_i,
   input wire lock_end_i,
   input wire other_lock_i,
   output reg secondary_parity_error_line_o = 1'h1,
   output reg primary_parity_error_line_o = 1'h1,
   output reg secondary_system_error_input_o = 1'h1,
   output reg p_frame_b_o = 1'h1,
   output reg p_lock_b_o = 1'h1,
   output wire s_lock_b_o
);
   // ----
   // Target reports and primary locked sequence
   // ----
   always @(posedge clock_i)
   begin
      secondary_parity_error_line_o <= !tgt_perr_i[0];
      primary_parity_error_line_o <= !tgt_perr_i[1];
      secondary_system_error_input_o <= !sys_err_i;
      p_frame_b_o <= !lock_go_i;
      if (lock_end_i)
         p_lock_b_o <= 1'h1;
      else if (!p_frame_b_o)
         p_lock_b_o <= 1'h0;
   end
   // Another secondary master holding its own lock
   assign s_lock_b_o = !other_lock_i;
endmodule

// ### dv/bec_top_tb.sv
// Self-checking bench for the bridge error and lock control block.
// Assumes bec_top, bec_far_end and the bound checker are compiled with it.
`timescale 1ns/10ps
module bec_top_tb;
   logic clock_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, lk_addr_i, rpt_addr_i, c, m, e;
   logic [3:0] lk_cmd_i, lk_be_i, rpt_cmd_i, rpt_be_i;
   logic [1:0] txn_kind_i, tgt_perr;
   logic reg_wr_i, reg_rd_i, dn_pw_perr_i, up_pw_perr_i, dn_wr_master_i, dn_wr_fwd_bad_i;
   logic up_wr_master_i, up_wr_fwd_bad_i, pw_target_abort_i, pw_master_abort_i, retry_i;
   logic txn_done_i, master_timeout_i, lk_rd_req_i, lk_par_i, queue_ahead_empty_i;
   logic s_bus_idle_i, s_rd_data_done_i, s_rd_abort_i, rpt_valid_i, rpt_lock_seq_i;
   logic sys_err, lock_go, lock_end, other_lock, d, f;
   logic [40:0] lkq[$];
   int n_fail = 0, checks = 0, k, b;
   wire [31:0] reg_rdata_o, lk_addr_o;
   wire [3:0] lk_cmd_o, lk_be_o;
   wire primary_parity_error_line_b_o, primary_parity_error_line_oe_o, lk_par_o;
   wire secondary_parity_error_line_b_o, secondary_parity_error_line_oe_o, discard_o;
   wire primary_system_error_line_b_o, primary_system_error_line_oe_o, target_retry_o;
   wire fwd_bad_par_dn_o, fwd_bad_par_up_o, target_abort_o, return_data_o, block_cross_o;
   wire no_prefetch_o, fwd_locked_o, issue_lock_rd_o, s_lock_b_o, s_lock_oe_o;
   wire primary_parity_error_line_b_i, secondary_parity_error_line_b_i, s_lock_b_i;
   wire secondary_system_error_input_b_i, p_lock_b_i, p_frame_b_i, fp_perr, fs_perr, fs_lock;
   wire [1:0] evt = {fwd_locked_o, issue_lock_rd_o};
   // ----
   // Wired lines, partner and design
   // ----
   assign primary_parity_error_line_b_i = fp_perr &
      (primary_parity_error_line_b_o | !primary_parity_error_line_oe_o);
   assign secondary_parity_error_line_b_i = fs_perr &
      (secondary_parity_error_line_b_o | !secondary_parity_error_line_oe_o);
   assign s_lock_b_i = fs_lock & (s_lock_b_o | !s_lock_oe_o);
   always #10 clock_i = ~clock_i;
   bec_far_end u_far (.clock_i(clock_i), .tgt_perr_i(tgt_perr), .sys_err_i(sys_err),
      .lock_go_i(lock_go), .lock_end_i(lock_end), .other_lock_i(other_lock),
      .secondary_parity_error_line_o(fs_perr), .primary_parity_error_line_o(fp_perr), .secondary_system_error_input_o(secondary_system_error_input_b_i),
      .p_frame_b_o(p_frame_b_i), .p_lock_b_o(p_lock_b_i), .s_lock_b_o(fs_lock));
   bec_top #(.RETRY_LIMIT(8)) uut (.*);
   // ----
   // Bench tasks
   // ----
   task chk(input [63:0] got, input [63:0] exp);
      begin
         checks++;
         if (got !== exp)
         begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] v);
      begin
         reg_addr_i <= a;
         reg_wdata_i <= v;
         reg_wr_i <= 1'h1;
         @(posedge clock_i);
         reg_wr_i <= 1'h0;
         @(posedge clock_i);
      end
   endtask
   task rchk(input [7:0] a, input [31:0] x);
      begin
         reg_addr_i <= a;
         reg_rd_i <= 1'h1;
         @(posedge clock_i);
         reg_rd_i <= 1'h0;
         @(negedge clock_i);
         chk(reg_rdata_o, x);
         @(posedge clock_i);
      end
   endtask
   task clr;
      begin
         wr(8'h04, 32'h3F);
         wr(8'h08, 32'hFF);
      end
   endtask
   task wait_on(input int i, input logic v);
      int j;
      begin
         @(negedge clock_i);
         for (j = 0; j < 80 && evt[i] !== v; j++)
            @(negedge clock_i);
         if (j == 80)
         begin
            n_fail++;
            wrap_up;
         end
         @(posedge clock_i);
      end
   endtask
   // ----
   // Scenarios
   // ----
   initial
   begin
      {reg_addr_i, reg_wdata_i, lk_addr_i, rpt_addr_i, lk_cmd_i, lk_be_i, rpt_cmd_i, rpt_be_i,
         txn_kind_i, tgt_perr, reg_wr_i, reg_rd_i, dn_pw_perr_i, up_pw_perr_i, dn_wr_master_i,
         dn_wr_fwd_bad_i, up_wr_master_i, up_wr_fwd_bad_i, pw_target_abort_i, pw_master_abort_i,
         retry_i, txn_done_i, master_timeout_i, lk_rd_req_i, lk_par_i, queue_ahead_empty_i,
         s_bus_idle_i, s_rd_data_done_i, s_rd_abort_i, rpt_valid_i, rpt_lock_seq_i, sys_err,
         lock_go, lock_end, other_lock} = '0;
      void'($urandom(1355));
      repeat (6) @(posedge clock_i);
      rst_b_i <= 1'h1;
      @(posedge clock_i);
      for (k = 0; k < 6; k++)
         rchk(8'(k * 4), 32'h0);
      for (k = 0; k < 4; k++)
      begin
         wr(8'h00, k);
         {dn_pw_perr_i, up_pw_perr_i} <= 2'h3;
         @(posedge clock_i);
         {dn_pw_perr_i, up_pw_perr_i} <= 2'h0;
         @(negedge clock_i);
         chk({fwd_bad_par_dn_o, fwd_bad_par_up_o}, 2'h3);
         @(negedge clock_i);
         chk(primary_parity_error_line_oe_o, k[0]);
         chk(secondary_parity_error_line_oe_o, k[1]);
         @(posedge clock_i);
         rchk(8'h04, 32'h09);
         clr;
      end
      for (k = 0; k < 12; k++)
      begin
         c = $urandom & 7;
         m = $urandom & 1;
         d = $urandom;
         f = $urandom;
         wr(8'h00, c);
         wr(8'h0C, m);
         {dn_wr_master_i, up_wr_master_i, dn_wr_fwd_bad_i, up_wr_fwd_bad_i} <= {!d, d, f, f};
         tgt_perr <= d ? 2'h2 : 2'h1;
         @(posedge clock_i);
         tgt_perr <= 2'h0;
         repeat (6) @(posedge clock_i);
         {dn_wr_master_i, up_wr_master_i} <= 2'h0;
         e = d ? {c[0], 1'h0} : {c[1], 4'h0};
         b = (c == 7 && m == 0 && !f);
         rchk(8'h04, e | b << 2);
         rchk(8'h08, b);
         clr;
      end
      wr(8'h00, 32'h0C);
      sys_err <= 1'h1;
      @(posedge clock_i);
      sys_err <= 1'h0;
      repeat (6) @(posedge clock_i);
      rchk(8'h04, 32'h24);
      rchk(8'h08, 32'h80);
      clr;
      wr(8'h00, 32'h14);
      for (k = 0; k < 6; k++)
      begin
         m = $urandom & 32'h3F;
         wr(8'h0C, m);
         b = k < 3 ? k + 3 : k == 3 ? 1 : k == 4 ? 2 : 6;
         txn_kind_i <= k[1:0];
         {master_timeout_i, pw_master_abort_i, pw_target_abort_i, retry_i} <=
            4'(1 << (k < 3 ? 0 : k - 2));
         repeat (k < 3 ? 8 : 1) @(posedge clock_i);
         {retry_i, pw_target_abort_i, pw_master_abort_i, master_timeout_i} <= 4'h0;
         @(negedge clock_i);
         if (k < 3)
            chk(discard_o, 1'h1);
         e = (b < 6 && m[b]) ? 0 : 1 << b;
         @(posedge clock_i);
         txn_done_i <= 1'h1;
         @(posedge clock_i);
         txn_done_i <= 1'h0;
         repeat (2) @(posedge clock_i);
         rchk(8'h04, e ? 4 : 0);
         rchk(8'h08, e);
         clr;
      end
      s_bus_idle_i <= 1'h1;
      for (k = 0; k < 3; k++)
      begin
         {other_lock, queue_ahead_empty_i} <= 2'h2;
         lkq.push_back({$urandom, 4'($urandom), 4'($urandom), 1'($urandom)});
         {lk_addr_i, lk_cmd_i, lk_be_i, lk_par_i} <= lkq[0];
         lk_rd_req_i <= 1'h1;
         @(posedge clock_i);
         lk_rd_req_i <= 1'h0;
         @(negedge clock_i);
         chk({target_retry_o, block_cross_o}, 2'h3);
         chk({lk_addr_o, lk_cmd_o, lk_be_o, lk_par_o}, lkq[0]);
         repeat (3) @(posedge clock_i);
         queue_ahead_empty_i <= 1'h1;
         repeat (3) @(posedge clock_i);
         other_lock <= 1'h0;
         wait_on(0, 1'h1);
         {lock_go, s_rd_abort_i, s_rd_data_done_i} <= {1'h1, k == 1, k != 1};
         @(posedge clock_i);
         {lock_go, s_rd_abort_i, s_rd_data_done_i} <= 3'h0;
         repeat (4) @(posedge clock_i);
         {rpt_addr_i, rpt_cmd_i, rpt_be_i, rpt_lock_seq_i} <= {lkq[0][40:1], 1'h1};
         rpt_valid_i <= (k != 2);
         master_timeout_i <= (k == 2);
         @(posedge clock_i);
         {rpt_valid_i, master_timeout_i} <= 2'h0;
         e = k == 0 ? 32'hA : k == 1 ? 32'h4 : 32'h1;
         @(negedge clock_i);
         chk({return_data_o, target_abort_o, fwd_locked_o, discard_o}, e);
         @(posedge clock_i);
         lock_end <= 1'h1;
         @(posedge clock_i);
         lock_end <= 1'h0;
         wait_on(1, 1'h0);
         @(negedge clock_i);
         chk({block_cross_o, s_lock_oe_o}, 2'h0);
         @(posedge clock_i);
         if (k == 2)
            rchk(8'h08, 32'h40);
         void'(lkq.pop_front());
      end
      wrap_up;
   end
endmodule
